// *** hdl/ach_pkg.sv ***
// Purpose: Constants for the card command handler
// Assumes: 200 MHz ref_clk, 32-bit register bus, one word per register
// Notes: Byte address of a register is four times its index
package ach_pkg;
   // ------------------------------------------------------------
   // Register indexes
   // ------------------------------------------------------------
   localparam logic [3:0] IDX_DATA = 4'h0;
   localparam logic [3:0] IDX_FEATURE = 4'h1;
   localparam logic [3:0] IDX_SEC_COUNT = 4'h2;
   localparam logic [3:0] IDX_SEC_NUMBER = 4'h3;
   localparam logic [3:0] IDX_CYL_LOW = 4'h4;
   localparam logic [3:0] IDX_CYL_HIGH = 4'h5;
   localparam logic [3:0] IDX_DRIVE_HEAD = 4'h6;
   localparam logic [3:0] IDX_COMMAND = 4'h7;
   localparam logic [3:0] IDX_ID_SEL = 4'h8;
   localparam logic [3:0] IDX_ID_DATA = 4'h9;
   localparam logic [3:0] IDX_POWER = 4'hA;
   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_IDLE_A = 8'hE3;
   localparam logic [7:0] OP_IDLE_B = 8'h97;
   localparam logic [7:0] OP_IDLE_IMM_A = 8'hE1;
   localparam logic [7:0] OP_IDLE_IMM_B = 8'h95;
   localparam logic [7:0] OP_INIT_PARAMS = 8'h91;
   localparam logic [7:0] OP_READ_BUFFER = 8'hE4;
   localparam logic [7:0] OP_READ_MULTIPLE = 8'hC4;
   localparam logic [7:0] OP_SET_MULTIPLE = 8'hC6;
   // ------------------------------------------------------------
   // Status, error and drive/head bits
   // ------------------------------------------------------------
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_DRQ = 3;
   localparam int ST_CORR = 2;
   localparam int ST_ERR = 0;
   localparam int ER_UNC = 6;
   localparam int ER_ABRT = 2;
   localparam int DH_LBA = 6;
   // ------------------------------------------------------------
   // Identify words and geometry
   // ------------------------------------------------------------
   localparam logic [7:0] IDW_DMA_MODE = 8'd52;
   localparam logic [7:0] IDW_XLAT_VALID = 8'd53;
   localparam logic [7:0] IDW_CUR_CYL = 8'd54;
   localparam logic [7:0] IDW_CUR_HEADS = 8'd55;
   localparam logic [7:0] IDW_CUR_SPT = 8'd56;
   localparam logic [7:0] IDW_CAP_LSW = 8'd57;
   localparam logic [7:0] IDW_CAP_MSW = 8'd58;
   localparam logic [7:0] IDW_MULT = 8'd59;
   localparam logic [7:0] IDW_LBA_LSW = 8'd60;
   localparam logic [7:0] IDW_LBA_MSW = 8'd61;
   localparam logic [15:0] DMA_NONE = 16'h0000;
   localparam logic [15:0] XLAT_VALID = 16'h0001;
   localparam logic [7:0] MULT_VALID = 8'h01;
   localparam logic [7:0] MULT_OFF = 8'h00;
   localparam logic [7:0] MULT_ONE = 8'h01;
   localparam logic [15:0] DEF_CYL = 16'h0100;
   localparam logic [7:0] DEF_HEADS = 8'h04;
   localparam logic [7:0] DEF_SPT = 8'h20;
   localparam logic [31:0] LBA_TOTAL = 32'h0002_0000;
   localparam logic [8:0] SECTORS_MAX = 9'h100;
   localparam logic [7:0] WORDS_LAST = 8'hFF;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int PD_STEP_MS = 5;
   localparam int PD_STEP_CYC_DEF = CLK_HZ / 1000 * PD_STEP_MS;
endpackage

// *** hdl/ach_card_cmd.sv ***
// Purpose: Task-file command handler for an ATA flash card
// Assumes: Avalon-MM slave, byte addresses, media engine on ref_clk
// Notes: Sector buffer holds one 512-byte sector
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ach_card_cmd
   import ach_pkg::*;
#(
   parameter int unsigned PD_STEP_CYC = PD_STEP_CYC_DEF
)
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic intrq,
   output logic media_rd_req,
   output logic [27:0] media_addr,
   output logic media_lba_mode,
   output logic media_sleep,
   input wire logic media_wvalid,
   input wire logic [15:0] media_wdata,
   input wire logic media_done,
   input wire logic media_err_corr,
   input wire logic media_err_unc
);
   typedef enum logic [2:0]
   {
      S_READY = 3'b000,
      S_EXEC = 3'b001,
      S_FETCH = 3'b010,
      S_XFER = 3'b011,
      S_NEXT = 3'b100
   } ach_state_e;

   ach_state_e state_r;
   logic ack_r;
   logic [7:0] feature_r, count_r, secnum_r, cyl_lo_r, cyl_hi_r, dh_r, cmd_r;
   logic [7:0] error_r, id_sel_r, mult_r, spt_r, heads_r;
   logic [8:0] remain_r;
   logic [15:0] buf_mem [0:255];
   logic [7:0] fill_ptr_r, rd_ptr_r;
   logic [15:0] rd_word;
   logic corr_r, err_r, fatal_r, intrq_r, buf_cmd_r;
   logic apd_en_r, sleep_r;
   logic [7:0] apd_limit_r, apd_cnt_r;
   logic [31:0] step_cnt_r;
   logic [31:0] cur_cap;
   logic [15:0] id_word;
   logic [7:0] status;
   logic [3:0] idx;
   logic rd_acc, wr_acc, cmd_wr, busy, data_pop, last_word;
   logic [27:0] lba_next;

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   // One wait state on every access keeps read data registered
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign idx = avs_address[5:2];
   assign rd_acc = avs_read & ack_r;
   assign wr_acc = avs_write & ack_r;
   assign busy = (state_r != S_READY) && (state_r != S_XFER);
   assign cmd_wr = wr_acc && idx == IDX_COMMAND && !busy;
   assign data_pop = rd_acc && idx == IDX_DATA && state_r == S_XFER;
   assign last_word = rd_ptr_r == WORDS_LAST;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read | avs_write) & ~ack_r;
   end

   // ------------------------------------------------------------
   // Identify words and status
   // ------------------------------------------------------------
   assign cur_cap = DEF_CYL * heads_r * spt_r;

   always_comb
   begin
      case (id_sel_r)
         IDW_DMA_MODE: id_word = DMA_NONE;
         IDW_XLAT_VALID: id_word = XLAT_VALID;
         IDW_CUR_CYL: id_word = DEF_CYL;
         IDW_CUR_HEADS: id_word = {8'h00, heads_r};
         IDW_CUR_SPT: id_word = {8'h00, spt_r};
         IDW_CAP_LSW: id_word = cur_cap[15:0];
         IDW_CAP_MSW: id_word = cur_cap[31:16];
         IDW_MULT: id_word = {MULT_VALID, mult_r};
         IDW_LBA_LSW: id_word = LBA_TOTAL[15:0];
         IDW_LBA_MSW: id_word = LBA_TOTAL[31:16];
         default: id_word = 16'h0000;
      endcase
   end

   always_comb
   begin
      status = 8'h00;
      status[ST_BUSY] = busy;
      status[ST_READY] = !busy;
      status[ST_DRQ] = state_r == S_XFER;
      status[ST_CORR] = corr_r;
      status[ST_ERR] = err_r;
   end

   assign rd_word = buf_mem[rd_ptr_r];

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         avs_readdata <= 32'h0000_0000;
      else if ((avs_read | avs_write) & ~ack_r)
      begin
         case (idx)
            IDX_DATA: avs_readdata <= {16'h0000, rd_word};
            IDX_FEATURE: avs_readdata <= {24'h000000, error_r};
            IDX_SEC_COUNT: avs_readdata <= {24'h000000, count_r};
            IDX_SEC_NUMBER: avs_readdata <= {24'h000000, secnum_r};
            IDX_CYL_LOW: avs_readdata <= {24'h000000, cyl_lo_r};
            IDX_CYL_HIGH: avs_readdata <= {24'h000000, cyl_hi_r};
            IDX_DRIVE_HEAD: avs_readdata <= {24'h000000, dh_r};
            IDX_COMMAND: avs_readdata <= {24'h000000, status};
            IDX_ID_SEL: avs_readdata <= {24'h000000, id_sel_r};
            IDX_ID_DATA: avs_readdata <= {16'h0000, id_word};
            IDX_POWER: avs_readdata <= {30'h0, apd_en_r, sleep_r};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Task file
   // ------------------------------------------------------------
   // Host writes are dropped while busy, as on a real drive
   assign lba_next = {dh_r[3:0], cyl_hi_r, cyl_lo_r, secnum_r} + 28'h1;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         feature_r <= 8'h00;
         count_r <= 8'h01;
         secnum_r <= 8'h01;
         cyl_lo_r <= 8'h00;
         cyl_hi_r <= 8'h00;
         dh_r <= 8'hA0;
         cmd_r <= 8'h00;
         id_sel_r <= 8'h00;
      end
      else if (wr_acc && !busy)
      begin
         case (idx)
            IDX_FEATURE: feature_r <= avs_writedata[7:0];
            IDX_SEC_COUNT: count_r <= avs_writedata[7:0];
            IDX_SEC_NUMBER: secnum_r <= avs_writedata[7:0];
            IDX_CYL_LOW: cyl_lo_r <= avs_writedata[7:0];
            IDX_CYL_HIGH: cyl_hi_r <= avs_writedata[7:0];
            IDX_DRIVE_HEAD: dh_r <= avs_writedata[7:0];
            IDX_COMMAND: cmd_r <= avs_writedata[7:0];
            IDX_ID_SEL: id_sel_r <= avs_writedata[7:0];
            default: ;
         endcase
      end
      else if (state_r == S_NEXT)
      begin
         // Advance only once the sector was read clean or corrected
         if (dh_r[DH_LBA])
            {dh_r[3:0], cyl_hi_r, cyl_lo_r, secnum_r} <= lba_next;
         else if (secnum_r < spt_r)
            secnum_r <= secnum_r + 8'h01;
         else
         begin
            secnum_r <= 8'h01;
            if ({4'h0, dh_r[3:0]} < heads_r - 8'h01)
               dh_r[3:0] <= dh_r[3:0] + 4'h1;
            else
            begin
               dh_r[3:0] <= 4'h0;
               {cyl_hi_r, cyl_lo_r} <= {cyl_hi_r, cyl_lo_r} + 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         state_r <= S_READY;
         remain_r <= 9'h000;
         error_r <= 8'h00;
         err_r <= 1'b0;
         corr_r <= 1'b0;
         fatal_r <= 1'b0;
         buf_cmd_r <= 1'b0;
         mult_r <= MULT_OFF;
         spt_r <= DEF_SPT;
         heads_r <= DEF_HEADS;
      end
      else
      begin
         case (state_r)
            S_READY:
            begin
               if (cmd_wr)
               begin
                  state_r <= S_EXEC;
                  error_r <= 8'h00;
                  err_r <= 1'b0;
                  corr_r <= 1'b0;
                  fatal_r <= 1'b0;
               end
            end
            S_EXEC:
            begin
               state_r <= S_READY;
               buf_cmd_r <= 1'b0;
               case (cmd_r)
                  OP_INIT_PARAMS:
                  begin
                     spt_r <= count_r;
                     heads_r <= {4'h0, dh_r[3:0]} + 8'h01;
                  end
                  OP_SET_MULTIPLE:
                  begin
                     // Only off or one sector per block is ever held
                     if (count_r == MULT_OFF || count_r == MULT_ONE)
                        mult_r <= count_r;
                     else
                     begin
                        error_r[ER_ABRT] <= 1'b1;
                        err_r <= 1'b1;
                     end
                  end
                  OP_READ_BUFFER:
                  begin
                     buf_cmd_r <= 1'b1;
                     remain_r <= 9'h001;
                     state_r <= S_XFER;
                  end
                  OP_READ_MULTIPLE:
                  begin
                     if (mult_r == MULT_OFF)
                     begin
                        error_r[ER_ABRT] <= 1'b1;
                        err_r <= 1'b1;
                     end
                     else
                     begin
                        // Block is one sector, so a partial block never occurs
                        remain_r <= (count_r == 8'h00) ? SECTORS_MAX
                                    : {1'b0, count_r};
                        state_r <= S_FETCH;
                     end
                  end
                  OP_IDLE_A, OP_IDLE_B, OP_IDLE_IMM_A, OP_IDLE_IMM_B: ;
                  default:
                  begin
                     error_r[ER_ABRT] <= 1'b1;
                     err_r <= 1'b1;
                  end
               endcase
            end
            S_FETCH:
            begin
               if (media_done)
               begin
                  state_r <= S_XFER;
                  if (media_err_unc)
                  begin
                     error_r[ER_UNC] <= 1'b1;
                     err_r <= 1'b1;
                     fatal_r <= 1'b1;
                  end
                  else if (media_err_corr)
                     corr_r <= 1'b1;
               end
            end
            S_XFER:
            begin
               if (data_pop && last_word)
               begin
                  if (remain_r == 9'h001 || fatal_r)
                     state_r <= S_READY;
                  else
                     state_r <= S_NEXT;
               end
            end
            S_NEXT:
            begin
               remain_r <= remain_r - 9'h001;
               corr_r <= 1'b0;
               state_r <= S_FETCH;
            end
            default: state_r <= S_READY;
         endcase
      end
   end

   assign media_rd_req = state_r == S_FETCH;
   assign media_addr = {dh_r[3:0], cyl_hi_r, cyl_lo_r, secnum_r};
   assign media_lba_mode = dh_r[DH_LBA];

   // ------------------------------------------------------------
   // Sector buffer
   // ------------------------------------------------------------
   // Faulty data stays here after an error for the host to inspect
   always_ff @(posedge ref_clk)
   begin
      if (state_r == S_FETCH && media_wvalid)
         buf_mem[fill_ptr_r] <= media_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         fill_ptr_r <= 8'h00;
      else if (state_r == S_FETCH && media_wvalid)
         fill_ptr_r <= fill_ptr_r + 8'h01;
      else if (state_r != S_FETCH)
         fill_ptr_r <= 8'h00;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         rd_ptr_r <= 8'h00;
      else if (data_pop)
         rd_ptr_r <= rd_ptr_r + 8'h01;
      else if (state_r != S_XFER)
         rd_ptr_r <= 8'h00;
   end

   // ------------------------------------------------------------
   // Host interrupt
   // ------------------------------------------------------------
   // Set wins over the clear from a status read or command write
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         intrq_r <= 1'b0;
      else if ((state_r == S_EXEC && cmd_r != OP_READ_MULTIPLE) ||
               (state_r == S_EXEC && mult_r == MULT_OFF))
         intrq_r <= 1'b1;
      else if (state_r == S_FETCH && media_done)
         intrq_r <= 1'b1;
      else if ((rd_acc && idx == IDX_COMMAND) || cmd_wr)
         intrq_r <= 1'b0;
   end

   assign intrq = intrq_r;

   // ------------------------------------------------------------
   // Automatic power-down
   // ------------------------------------------------------------
   // Step counter is a parameter so a bench can shorten 5 ms
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         apd_en_r <= 1'b0;
         apd_limit_r <= 8'h00;
      end
      else if (state_r == S_EXEC &&
               (cmd_r == OP_IDLE_A || cmd_r == OP_IDLE_B))
      begin
         apd_en_r <= count_r != 8'h00;
         apd_limit_r <= count_r;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         step_cnt_r <= 32'h0000_0000;
         apd_cnt_r <= 8'h00;
         sleep_r <= 1'b0;
      end
      else if (cmd_wr || state_r != S_READY)
      begin
         step_cnt_r <= 32'h0000_0000;
         apd_cnt_r <= 8'h00;
         sleep_r <= 1'b0;
      end
      else if (apd_en_r && !sleep_r)
      begin
         if (step_cnt_r == PD_STEP_CYC - 1)
         begin
            step_cnt_r <= 32'h0000_0000;
            if (apd_cnt_r == apd_limit_r - 8'h01)
               sleep_r <= 1'b1;
            else
               apd_cnt_r <= apd_cnt_r + 8'h01;
         end
         else
            step_cnt_r <= step_cnt_r + 32'h0000_0001;
      end
   end

   assign media_sleep = sleep_r;
endmodule
`default_nettype wire

// *** verif/ach_card_cmd_chk.sv ***
// Purpose: Port checks for the card command handler
// Assumes: One clock, sync active-low reset
// Notes: Sees top-level ports only
`timescale 1ns/1ps
`default_nettype none
module ach_card_cmd_chk
   import ach_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic intrq,
   input wire logic media_rd_req,
   input wire logic [27:0] media_addr,
   input wire logic media_lba_mode,
   input wire logic media_sleep,
   input wire logic media_wvalid,
   input wire logic [15:0] media_wdata,
   input wire logic media_done,
   input wire logic media_err_corr,
   input wire logic media_err_unc
);
   logic wr_acc;
   logic cmd_acc;
   logic idle_op;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   assign wr_acc = avs_write && !avs_waitrequest;
   assign cmd_acc = wr_acc && avs_address[5:2] == IDX_COMMAND;
   assign idle_op = avs_writedata[7:0] inside
      {OP_IDLE_A, OP_IDLE_B, OP_IDLE_IMM_A, OP_IDLE_IMM_B};
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   chk_wait_once:
      assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("waitrequest held too long");
   chk_idle_intr:
      assert property (cmd_acc && idle_op |-> ##[1:3] intrq)
      else $error("no interrupt after idle command");
   chk_fetch_quiet:
      assert property (media_rd_req && !media_done |=> !$rose(intrq))
      else $error("interrupt raised mid sector");
   chk_addr_hold:
      assert property (media_rd_req && $past(media_rd_req)
      |-> $stable(media_addr)) else $error("address moved during fetch");
   chk_fetch_end:
      assert property (media_rd_req && media_done |=> !media_rd_req)
      else $error("fetch not ended by done");
   chk_drq_intr:
      assert property (media_rd_req && media_done |=> intrq)
      else $error("no interrupt at block start");
   chk_sleep_wake:
      assert property (media_sleep && cmd_acc |-> ##[1:3] !media_sleep)
      else $error("command did not wake card");
   chk_sec_load:
      assert property (wr_acc && avs_address[5:2] == IDX_SEC_NUMBER &&
      !media_rd_req |=> media_addr[7:0] == $past(avs_writedata[7:0]))
      else $error("sector number not loaded");
endmodule
bind ach_card_cmd ach_card_cmd_chk u_chk (.ref_clk(ref_clk),
   .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .intrq(intrq), .media_rd_req(media_rd_req), .media_addr(media_addr),
   .media_lba_mode(media_lba_mode), .media_sleep(media_sleep),
   .media_wvalid(media_wvalid), .media_wdata(media_wdata),
   .media_done(media_done), .media_err_corr(media_err_corr),
   .media_err_unc(media_err_unc));
`default_nettype wire

// *** verif/ach_media_model.sv ***
// Purpose: Media engine stand-in for the command handler
// Assumes: Sector streamed word by word after dly cycles
// Notes: Idle data is inverted so stale words are caught
`timescale 1ns/1ps
`default_nettype none
module ach_media_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic media_rd_req,
   input wire logic [27:0] media_addr,
   input wire logic [7:0] dly,
   input wire logic inj_corr,
   input wire logic inj_unc,
   output logic media_wvalid,
   output logic [15:0] media_wdata,
   output logic media_done,
   output logic media_err_corr,
   output logic media_err_unc
);
   int cnt;
   logic [15:0] word;
   always_ff @(posedge clk)
   begin
      if (!rst_b || !media_rd_req)
         cnt <= 0;
      else if (cnt <= dly + 256)
         cnt <= cnt + 1;
   end
   // Whole buffer filled before done, never after
   assign media_wvalid = media_rd_req && cnt >= dly && cnt < dly + 256;
   assign word = {media_addr[7:0], cnt[7:0] - dly};
   assign media_wdata = media_wvalid ? word : ~word;
   assign media_done = media_rd_req && cnt == dly + 256;
   assign media_err_corr = media_done && inj_corr;
   assign media_err_unc = media_done && inj_unc;
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the card command handler
// Assumes: Power-down step shortened to 20 cycles
// Notes: Data word pattern is sector number then word index
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ach_pkg::*;
;
   logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, intrq;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, v;
   logic media_rd_req, media_lba_mode, media_sleep, media_wvalid;
   logic [27:0] media_addr;
   logic [15:0] media_wdata;
   logic media_done, media_err_corr, media_err_unc, inj_corr, inj_unc;
   logic [7:0] dly;
   int errors;
   int checks_done;
   ach_card_cmd #(.PD_STEP_CYC(20)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .intrq(intrq),
      .media_rd_req(media_rd_req), .media_addr(media_addr),
      .media_lba_mode(media_lba_mode), .media_sleep(media_sleep),
      .media_wvalid(media_wvalid), .media_wdata(media_wdata),
      .media_done(media_done), .media_err_corr(media_err_corr),
      .media_err_unc(media_err_unc));
   ach_media_model u_media (.clk(ref_clk), .rst_b(rst_b), .dly(dly),
      .media_rd_req(media_rd_req), .media_addr(media_addr),
      .inj_corr(inj_corr), .inj_unc(inj_unc), .media_wvalid(media_wvalid),
      .media_wdata(media_wdata), .media_done(media_done),
      .media_err_corr(media_err_corr), .media_err_unc(media_err_unc));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stall(input string what);
      errors++;
      $display("unexpected %s: expected response seen timeout", what);
      final_report();
   endtask
   // Request held from an edge until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] idx,
      input logic [7:0] wd, output logic [31:0] rd);
      int n;
      @(posedge ref_clk);
      avs_address <= {idx, 2'h0};
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 40);
      if (avs_waitrequest !== 1'b0)
         stall("waitrequest");
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wirq();
      int n;
      n = 0;
      while (intrq !== 1'b1 && n < 2000)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 2000)
         stall("interrupt");
   endtask
   task automatic cmd(input logic [7:0] op);
      bus(1'b1, IDX_COMMAND, op, v);
      wirq();
      bus(1'b0, IDX_COMMAND, 8'h00, v);
   endtask
   task automatic idw(input logic [7:0] w, input logic [15:0] exp);
      bus(1'b1, IDX_ID_SEL, w, v);
      bus(1'b0, IDX_ID_DATA, 8'h00, v);
      chk("identify word", {16'h0, exp}, v);
   endtask
   task automatic rdm(input logic [7:0] cnt, input logic [7:0] sec,
      input logic [7:0] dh);
      bus(1'b1, IDX_SEC_COUNT, cnt, v);
      bus(1'b1, IDX_SEC_NUMBER, sec, v);
      bus(1'b1, IDX_CYL_LOW, 8'h00, v);
      bus(1'b1, IDX_CYL_HIGH, 8'h00, v);
      bus(1'b1, IDX_DRIVE_HEAD, dh, v);
      bus(1'b1, IDX_COMMAND, OP_READ_MULTIPLE, v);
   endtask
   // One block: interrupt, status, then a whole 512-byte sector
   task automatic take(input logic [7:0] sec, input logic [7:0] st);
      wirq();
      bus(1'b0, IDX_COMMAND, 8'h00, v);
      chk("status", {24'h0, st}, v & 32'h8D);
      for (int k = 0; k < 256; k++)
      begin
         bus(1'b0, IDX_DATA, 8'h00, v);
         chk("data word", {16'h0, sec, k[7:0]}, v);
      end
   endtask
   task automatic s_idle();
      logic [7:0] ops [4] = '{OP_IDLE_A, OP_IDLE_B, OP_IDLE_IMM_A,
         OP_IDLE_IMM_B};
      bus(1'b1, IDX_SEC_COUNT, 8'h00, v);
      foreach (ops[i])
      begin
         cmd(ops[i]);
         chk("idle status", 32'h0, v & 32'h8D);
      end
      bus(1'b0, IDX_POWER, 8'h00, v);
      chk("auto power-down", 32'h0, v & 32'h2);
      bus(1'b1, IDX_SEC_COUNT, 8'h02, v);
      cmd(OP_IDLE_A);
      bus(1'b0, IDX_POWER, 8'h00, v);
      chk("auto power-down", 32'h2, v & 32'h2);
      repeat (25) @(posedge ref_clk);
      chk("sleep early", 32'h0, {31'h0, media_sleep});
      repeat (25) @(posedge ref_clk);
      chk("sleep late", 32'h1, {31'h0, media_sleep});
      cmd(OP_IDLE_IMM_A);
      chk("sleep woken", 32'h0, {31'h0, media_sleep});
      bus(1'b1, IDX_SEC_COUNT, 8'h00, v);
      cmd(OP_IDLE_B);
      repeat (80) @(posedge ref_clk);
      chk("sleep off", 32'h0, {31'h0, media_sleep});
   endtask
   task automatic s_setup();
      logic [31:0] cap;
      cap = {16'h0, DEF_CYL} * 32'd128;
      bus(1'b0, IDX_COMMAND, 8'h00, v);
      chk("reset status", 32'h40, v);
      idw(IDW_DMA_MODE, DMA_NONE);
      idw(IDW_XLAT_VALID, XLAT_VALID);
      idw(IDW_MULT, 16'h0100);
      idw(IDW_LBA_LSW, LBA_TOTAL[15:0]);
      idw(IDW_LBA_MSW, LBA_TOTAL[31:16]);
      bus(1'b1, IDX_SEC_COUNT, 8'h10, v);
      bus(1'b1, IDX_CYL_LOW, 8'h55, v);
      bus(1'b1, IDX_DRIVE_HEAD, 8'hA7, v);
      cmd(OP_INIT_PARAMS);
      idw(IDW_CUR_HEADS, 16'h0008);
      idw(IDW_CUR_SPT, 16'h0010);
      idw(IDW_CUR_CYL, DEF_CYL);
      idw(IDW_CAP_LSW, cap[15:0]);
      idw(IDW_CAP_MSW, cap[31:16]);
      rdm(8'h02, 8'h10, 8'hE0);
      wirq();
      bus(1'b0, IDX_COMMAND, 8'h00, v);
      chk("abort status", 32'h01, v & 32'h8D);
      bus(1'b0, IDX_FEATURE, 8'h00, v);
      chk("abort error", 32'h04, v & 32'h04);
      bus(1'b1, IDX_SEC_COUNT, 8'h01, v);
      cmd(OP_SET_MULTIPLE);
      idw(IDW_MULT, {MULT_VALID, MULT_ONE});
   endtask
   task automatic s_reads();
      dly <= 8'h09;
      rdm(8'h02, 8'h10, 8'hE0);
      chk("lba mode", 32'h1, {31'h0, media_lba_mode});
      take(8'h10, 8'h08);
      take(8'h11, 8'h08);
      repeat (4) @(posedge ref_clk);
      chk("end interrupt", 32'h0, {31'h0, intrq});
      bus(1'b0, IDX_SEC_NUMBER, 8'h00, v);
      chk("last sector", 32'h11, v);
      inj_unc <= 1'b1;
      rdm(8'h03, 8'h20, 8'hE0);
      take(8'h20, 8'h09);
      inj_unc <= 1'b0;
      bus(1'b0, IDX_FEATURE, 8'h00, v);
      chk("media error", 32'h40, v & 32'h40);
      repeat (30) @(posedge ref_clk);
      chk("fetch stopped", 32'h0, {31'h0, media_rd_req});
      bus(1'b0, IDX_SEC_NUMBER, 8'h00, v);
      chk("failing sector", 32'h20, v);
      dly <= 8'h00;
      inj_corr <= 1'b1;
      rdm(8'h02, 8'h30, 8'hE0);
      take(8'h30, 8'h0C);
      inj_corr <= 1'b0;
      take(8'h31, 8'h08);
      bus(1'b1, IDX_COMMAND, OP_READ_BUFFER, v);
      take(8'h31, 8'h08);
      rdm(8'h02, 8'h10, 8'hA0);
      take(8'h10, 8'h08);
      take(8'h01, 8'h08);
      bus(1'b0, IDX_DRIVE_HEAD, 8'h00, v);
      chk("chs head", 32'hA1, v);
   endtask
   initial
   begin
      errors = 0;
      checks_done = 0;
      rst_b = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      dly = 8'h03;
      inj_corr = 1'b0;
      inj_unc = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      s_setup();
      s_idle();
      s_reads();
      final_report();
   end
endmodule
`default_nettype wire
